// ===== ptm_pkg.sv
`default_nettype none

package ptm_pkg;

  // ------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ------------------------------------------------------------
  localparam int unsigned WB_AW = 10;
  localparam logic [7:0] IDX_GLOBAL_INTERRUPT_CONTROL = 8'h0b;
  localparam logic [7:0] IDX_PERIPHERAL_IRQ_FLAGS = 8'h0c;
  localparam logic [7:0] IDX_PERIOD_TIMER_COUNT = 8'h11;
  localparam logic [7:0] IDX_PERIOD_TIMER_CONTROL = 8'h12;
  localparam logic [7:0] IDX_PERIPHERAL_IRQ_ENABLES = 8'h8c;
  localparam logic [7:0] IDX_PERIOD_LIMIT = 8'h92;

  // ------------------------------------------------------------
  // reset values and field positions
  // ------------------------------------------------------------
  localparam logic [7:0] RST_COUNT = 8'h00;
  localparam logic [7:0] RST_PERIOD = 8'hff;
  localparam logic [6:0] RST_CONTROL = 7'h00;
  localparam int unsigned CTL_PRESC_LSB = 0;
  localparam int unsigned CTL_RUN_BIT = 2;
  localparam int unsigned CTL_POST_LSB = 3;
  localparam int unsigned MATCH_FLAG_BIT = 1;
  localparam int unsigned MATCH_ENABLE_BIT = 1;

  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int unsigned INST_DIV = 4; // oscillator cycles per instruction cycle
  localparam logic [1:0] PRESC_DIV1 = 2'h0;
  localparam logic [1:0] PRESC_DIV4 = 2'h1;
  localparam logic [3:0] PRESC_LAST1 = 4'h0;
  localparam logic [3:0] PRESC_LAST4 = 4'h3;
  localparam logic [3:0] PRESC_LAST16 = 4'hf;

  // last prescaler count before a timer advance; 1x means sixteen
  function automatic logic [3:0] ptm_presc_last(input logic [1:0] sel);
    logic [3:0] r;
    r = PRESC_LAST16;
    if (sel == PRESC_DIV1) begin
      r = PRESC_LAST1;
    end else if (sel == PRESC_DIV4) begin
      r = PRESC_LAST4;
    end
    return r;
  endfunction

endpackage

`default_nettype wire

// ===== ptm_scl_if.sv
`default_nettype none

// scaler control and events between the register side and the scalers
interface ptm_scl_if;
  logic clr;
  logic run;
  logic [1:0] presc_sel;
  logic [3:0] post_sel;
  logic match;
  logic tick;
  logic post_evt;

  modport ctl (output clr, output run, output presc_sel, output post_sel, output match,
               input tick, input post_evt);
  modport scl (input clr, input run, input presc_sel, input post_sel, input match,
               output tick, output post_evt);
endinterface

`default_nettype wire

// ===== ptm_scaler.sv
`default_nettype none

module ptm_scaler #(
  parameter int unsigned INST_DIV = ptm_pkg::INST_DIV
) (
  // clock and reset
  input wire logic MCLK,
  input wire logic RST,
  // scaler control and events
  ptm_scl_if.scl s
);
  import ptm_pkg::*;

  localparam int unsigned IW = (INST_DIV > 1) ? $clog2(INST_DIV) : 1;
  localparam logic [IW-1:0] INST_LAST = IW'(INST_DIV - 1);

  // the divider needs at least two phases to make a one-cycle enable
  if (INST_DIV < 2) begin : g_bad_div
    $error("ptm_scaler: INST_DIV must be at least 2");
  end

  logic [IW-1:0] inst_cnt, next_inst_cnt;
  logic [3:0] pre_cnt, next_pre_cnt;
  logic [3:0] post_cnt, next_post_cnt;
  logic inst_en;
  logic pre_wrap;

  // ------------------------------------------------------------
  // dividers
  // ------------------------------------------------------------
  // instruction clock runs free; writes must not shift its phase
  always_comb begin
    inst_en = (inst_cnt == INST_LAST);
    next_inst_cnt = inst_en ? '0 : inst_cnt + 1'b1;
    pre_wrap = (pre_cnt == ptm_presc_last(s.presc_sel));
    s.tick = s.run && inst_en && pre_wrap && !s.clr;
    next_pre_cnt = pre_cnt;
    if (s.clr) begin
      next_pre_cnt = 4'h0;
    end else if (s.run && inst_en) begin
      next_pre_cnt = pre_wrap ? 4'h0 : pre_cnt + 4'h1;
    end
    s.post_evt = s.match && (post_cnt == s.post_sel) && !s.clr;
    next_post_cnt = post_cnt;
    if (s.clr) begin
      next_post_cnt = 4'h0;
    end else if (s.match) begin
      next_post_cnt = (post_cnt == s.post_sel) ? 4'h0 : post_cnt + 4'h1;
    end
  end

  // register the divider state
  always_ff @(posedge MCLK) begin
    if (RST) begin
      inst_cnt <= '0;
      pre_cnt <= 4'h0;
      post_cnt <= 4'h0;
    end else begin
      inst_cnt <= next_inst_cnt;
      pre_cnt <= next_pre_cnt;
      post_cnt <= next_post_cnt;
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RST);

  chk_scaler_clear: assert property (s.clr |=> pre_cnt == 4'h0 && post_cnt == 4'h0)
    else $error("scaler counters not cleared after a clear");
  chk_presc_tick: assert property (s.tick |-> inst_en && pre_cnt == ptm_presc_last(s.presc_sel))
    else $error("timer advance at the wrong prescaler phase");
  chk_post_count: assert property (s.post_evt |-> post_cnt == s.post_sel ##1 post_cnt == 4'h0)
    else $error("postscaler event at wrong match count");
  chk_stop_freeze: assert property (!s.run && !s.clr |=> $stable(pre_cnt) && !$past(s.tick))
    else $error("prescaler moved while stopped");
endmodule

`default_nettype wire

// ===== ptm_top.sv
// Local design decision: register access over Wishbone.
`default_nettype none

module ptm_top #(
  parameter int unsigned TMR_W = 8
) (
  // clock and reset
  input wire logic MCLK,
  input wire logic RST,
  // wishbone slave
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [ptm_pkg::WB_AW-1:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  // time base to sync serial port and pwm units
  output logic MATCH_PULSE,
  output logic [7:0] TIME_BASE_COUNT,
  // interrupt request
  output logic MATCH_IRQ
);
  import ptm_pkg::*;

  // refused at elaboration; the register map has no room for a wider count
  if (TMR_W != 8) begin : g_bad_width
    $error("ptm_top: only an 8-bit timer is supported");
  end

  ptm_scl_if scl_bus ();

  ptm_scaler #(
    .INST_DIV(INST_DIV)
  ) u_scaler (
    .MCLK(MCLK),
    .RST(RST),
    .s(scl_bus.scl)
  );

  logic [7:0] count, next_count;
  logic [7:0] period, next_period;
  logic [6:0] control, next_control;
  logic match_flag, next_match_flag;
  logic match_irq_enable, next_match_irq_enable;
  logic ack, next_ack;
  logic [31:0] rdata, next_rdata;
  logic match_pulse, next_match_pulse;
  logic irq, next_irq;

  logic access;
  logic wr_go;
  logic [7:0] idx;
  logic count_wr;
  logic control_wr;
  logic period_wr;
  logic flags_wr;
  logic enables_wr;
  logic match;

  // ------------------------------------------------------------
  // bus decode
  // ------------------------------------------------------------
  // writes land on the edge where ack is seen, matching a classic master
  always_comb begin
    access = WB_CYC_I && WB_STB_I;
    idx = WB_ADR_I[WB_AW-1:2];
    wr_go = access && WB_WE_I && ack && WB_SEL_I[0];
    count_wr = wr_go && (idx == IDX_PERIOD_TIMER_COUNT);
    control_wr = wr_go && (idx == IDX_PERIOD_TIMER_CONTROL);
    period_wr = wr_go && (idx == IDX_PERIOD_LIMIT);
    flags_wr = wr_go && (idx == IDX_PERIPHERAL_IRQ_FLAGS);
    enables_wr = wr_go && (idx == IDX_PERIPHERAL_IRQ_ENABLES);
  end

  // one wait state, ack for exactly one cycle
  always_comb begin
    next_ack = access && !ack;
    next_rdata = rdata;
    if (access && !ack) begin
      next_rdata = 32'h0000_0000; // unmapped and global control read zero
      case (idx)
        IDX_PERIOD_TIMER_COUNT: next_rdata = {24'h00_0000, count};
        IDX_PERIOD_TIMER_CONTROL: next_rdata = {24'h00_0000, 1'b0, control};
        IDX_PERIOD_LIMIT: next_rdata = {24'h00_0000, period};
        IDX_PERIPHERAL_IRQ_FLAGS: next_rdata = 32'(match_flag) << MATCH_FLAG_BIT;
        IDX_PERIPHERAL_IRQ_ENABLES: next_rdata = 32'(match_irq_enable) << MATCH_ENABLE_BIT;
        default: next_rdata = 32'h0000_0000;
      endcase
    end
  end

  // ------------------------------------------------------------
  // scaler control
  // ------------------------------------------------------------
  always_comb begin
    scl_bus.clr = count_wr || control_wr;
    scl_bus.run = control[CTL_RUN_BIT];
    scl_bus.presc_sel = control[CTL_PRESC_LSB +: 2];
    scl_bus.post_sel = control[CTL_POST_LSB +: 4];
    match = scl_bus.tick && (count == period);
    scl_bus.match = match;
  end

  // ------------------------------------------------------------
  // timer state
  // ------------------------------------------------------------
  // a count write beats a coinciding advance; tick is already masked by it
  always_comb begin
    next_count = count;
    if (count_wr) begin
      next_count = WB_DAT_I[7:0];
    end else if (scl_bus.tick) begin
      next_count = match ? 8'h00 : count + 8'h01;
    end
    next_period = period_wr ? WB_DAT_I[7:0] : period;
    next_control = control_wr ? WB_DAT_I[6:0] : control;
    next_match_irq_enable = enables_wr ? WB_DAT_I[MATCH_ENABLE_BIT] : match_irq_enable;
    // hardware set wins over a software clear in the same cycle
    next_match_flag = match_flag;
    if (scl_bus.post_evt) begin
      next_match_flag = 1'b1;
    end else if (flags_wr) begin
      next_match_flag = WB_DAT_I[MATCH_FLAG_BIT];
    end
    next_match_pulse = match;
    next_irq = next_match_flag && next_match_irq_enable;
  end

  // register all state
  always_ff @(posedge MCLK) begin
    if (RST) begin
      count <= RST_COUNT;
      period <= RST_PERIOD;
      control <= RST_CONTROL;
      match_flag <= 1'b0;
      match_irq_enable <= 1'b0;
      ack <= 1'b0;
      rdata <= 32'h0000_0000;
      match_pulse <= 1'b0;
      irq <= 1'b0;
    end else begin
      count <= next_count;
      period <= next_period;
      control <= next_control;
      match_flag <= next_match_flag;
      match_irq_enable <= next_match_irq_enable;
      ack <= next_ack;
      rdata <= next_rdata;
      match_pulse <= next_match_pulse;
      irq <= next_irq;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  // all straight from flops; the pwm units compare against the live count
  always_comb begin
    WB_ACK_O = ack;
    WB_DAT_O = rdata;
    MATCH_PULSE = match_pulse;
    TIME_BASE_COUNT = count;
    MATCH_IRQ = irq;
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RST);

  sequence s_last_step;
    scl_bus.tick && count == period && !count_wr;
  endsequence

  sequence s_flag_armed;
    match_flag && match_irq_enable;
  endsequence

  chk_count_reset: assert property ($fell(RST) |-> count == 8'h00 && !match_flag)
    else $error("count not zero after reset");
  chk_period_reset: assert property ($fell(RST) |-> period == 8'hff && control == 7'h00)
    else $error("period or control wrong after reset");
  chk_roll_over: assert property (s_last_step |=> count == 8'h00 && MATCH_PULSE)
    else $error("count did not roll over on match");
  chk_count_step: assert property (scl_bus.tick && count != period && !count_wr
                                   |=> count == $past(count) + 8'h01)
    else $error("count did not advance by one");
  chk_stop_hold: assert property (!control[CTL_RUN_BIT] && !count_wr |=> count == $past(count))
    else $error("count moved while stopped");
  chk_ctl_keeps: assert property (control_wr |=> count == $past(count))
    else $error("control write changed the count");
  chk_match_out: assert property (MATCH_PULSE |-> $past(count) == $past(period) && count == 8'h00)
    else $error("match pulse without a period match");
  chk_flag_set: assert property (scl_bus.post_evt |=> match_flag ##1 match_flag || $past(flags_wr))
    else $error("postscaled match did not set the flag");
  chk_ctl_msb: assert property (WB_ACK_O && !WB_WE_I && idx == IDX_PERIOD_TIMER_CONTROL
                                |-> WB_DAT_O[31:7] == 25'h0)
    else $error("control bit seven read as one");
  chk_irq_follow: assert property (s_flag_armed |-> MATCH_IRQ ##1 (MATCH_IRQ || !(match_flag && match_irq_enable)))
    else $error("interrupt request does not follow flag and enable");
  chk_ack_pulse: assert property (WB_ACK_O |=> !WB_ACK_O)
    else $error("ack held longer than one cycle");
  chk_count_write: assert property (count_wr |=> count == $past(WB_DAT_I[7:0]))
    else $error("count write did not land");
  chk_period_write: assert property (period_wr |=> period == $past(WB_DAT_I[7:0]))
    else $error("period write did not land");
  chk_flag_hold: assert property (match_flag && !flags_wr |=> match_flag)
    else $error("match flag dropped without a clear");
  chk_read_upper: assert property (WB_ACK_O |-> WB_DAT_O[31:8] == 24'h00_0000)
    else $error("read data above bit seven not zero");
endmodule

`default_nettype wire

// ===== period_timer_8bit_tb.sv
`default_nettype none

module period_timer_8bit_tb;
  timeunit 1ns;
  timeprecision 1ps;

  // ------------------------------------------------------------
  // bench signals
  // ------------------------------------------------------------
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [ptm_pkg::WB_AW-1:0] adr = '0;
  logic [3:0] sel = 4'hf;
  logic [31:0] dat_w = 32'h0;
  logic [31:0] dat_r;
  logic ack;
  logic pulse;
  logic irq;
  logic [7:0] tb_count;
  logic [31:0] rd;
  int errors = 0;
  int compares = 0;
  int cycles = 0;
  int seed = 53916;
  int p;
  int q;
  int n;
  int k;
  int t0;
  int mx;

  ptm_top ptm_top_inst (
    .MCLK(mclk), .RST(rst), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr),
    .WB_SEL_I(sel), .WB_DAT_I(dat_w), .WB_DAT_O(dat_r), .WB_ACK_O(ack),
    .MATCH_PULSE(pulse), .TIME_BASE_COUNT(tb_count), .MATCH_IRQ(irq)
  );

  // 125 MHz clock
  initial begin
    forever #4 mclk = ~mclk;
  end

  // cycle stamp and hang guard; all tests fit well inside this ceiling
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      errors++;
      tally_and_finish();
    end
  end

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  // classic cycle; request held up to the edge that samples ack high
  task automatic wb(input logic w, input logic [7:0] idx, input logic [7:0] d);
    int c;
    c = 0;
    @(posedge mclk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {idx, 2'b00};
    dat_w <= {24'h0, d};
    do begin
      @(posedge mclk);
      c++;
    end while (ack !== 1'b1);
    chk("wb_wait", 2, c);
    rd = dat_r;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask

  // waits for the next match pulse, tracking the highest count seen
  task automatic wait_pulse();
    int c;
    c = 0;
    do begin
      @(negedge mclk);
      c++;
      if (tb_count > mx) mx = tb_count;
    end while (pulse !== 1'b1 && c < 2000);
  endtask

  task automatic tally_and_finish();
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
    // reset values, unmapped place reads zero
    wb(0, ptm_pkg::IDX_PERIOD_TIMER_COUNT, 0); chk("count", 0, rd);
    wb(0, ptm_pkg::IDX_PERIOD_TIMER_CONTROL, 0); chk("control", 0, rd);
    wb(0, ptm_pkg::IDX_PERIOD_LIMIT, 0); chk("period", 32'hff, rd);
    wb(0, ptm_pkg::IDX_PERIPHERAL_IRQ_FLAGS, 0); chk("flags", 0, rd);
    wb(0, 8'h40, 0); chk("unmapped", 0, rd);
    $display("test reset values done");
    // register access; top control bit never sticks
    p = 2 + ($random(seed) & 7);
    wb(1, ptm_pkg::IDX_PERIOD_LIMIT, p[7:0]);
    wb(0, ptm_pkg::IDX_PERIOD_LIMIT, 0); chk("period_rw", p, rd);
    sel <= 4'he;
    wb(1, ptm_pkg::IDX_PERIOD_LIMIT, 8'h00);
    sel <= 4'hf;
    wb(0, ptm_pkg::IDX_PERIOD_LIMIT, 0); chk("period_sel", p, rd);
    wb(1, ptm_pkg::IDX_PERIOD_TIMER_CONTROL, 8'hff);
    wb(0, ptm_pkg::IDX_PERIOD_TIMER_CONTROL, 0); chk("control_rw", 32'h7f, rd);
    wb(1, ptm_pkg::IDX_PERIOD_TIMER_CONTROL, 8'h00);
    wb(1, ptm_pkg::IDX_PERIOD_TIMER_COUNT, 8'h5a);
    wb(0, ptm_pkg::IDX_PERIOD_TIMER_COUNT, 0); chk("count_rw", 32'h5a, rd);
    wb(1, ptm_pkg::IDX_PERIOD_TIMER_COUNT, 8'h00);
    $display("test register access done");
    // every prescale code: match spacing, rollover and count at match
    for (int s = 0; s < 4; s++) begin
      q = (s == 0) ? 1 : (s == 1) ? 4 : 16;
      wb(1, ptm_pkg::IDX_PERIOD_TIMER_CONTROL, 8'h04 | s[7:0]);
      wait_pulse();
      t0 = cycles;
      mx = 0;
      wait_pulse();
      chk("match_spacing", (p + 1) * 4 * q, cycles - t0);
      chk("max_count", p, mx);
      chk("count_at_match", 0, {24'h0, tb_count});
    end
    $display("test prescale done");
    // postscale codes 0, 1, 15 and one random, counted to the request
    wb(1, ptm_pkg::IDX_PERIPHERAL_IRQ_ENABLES, 8'h02);
    wb(0, ptm_pkg::IDX_PERIPHERAL_IRQ_ENABLES, 0); chk("enables", 32'h2, rd);
    for (int i = 0; i < 4; i++) begin
      q = (i == 0) ? 0 : (i == 1) ? 1 : (i == 2) ? 15 : ($random(seed) & 15);
      wb(1, ptm_pkg::IDX_PERIOD_TIMER_CONTROL, 8'h00);
      wb(1, ptm_pkg::IDX_PERIPHERAL_IRQ_FLAGS, 8'h00);
      wb(1, ptm_pkg::IDX_PERIOD_TIMER_CONTROL, {1'b0, q[3:0], 3'b100});
      n = 0;
      k = 0;
      do begin
        @(negedge mclk);
        k++;
        if (pulse === 1'b1) n++;
      end while (irq !== 1'b1 && k < 5000);
      chk("matches_per_flag", q + 1, n);
    end
    // stop first so only the latch can keep the flag up
    wb(1, ptm_pkg::IDX_PERIOD_TIMER_CONTROL, 8'h00);
    repeat (50) @(posedge mclk);
    wb(0, ptm_pkg::IDX_PERIPHERAL_IRQ_FLAGS, 0); chk("flag_held", 32'h2, rd);
    wb(1, ptm_pkg::IDX_PERIPHERAL_IRQ_ENABLES, 8'h00);
    repeat (2) @(negedge mclk);
    chk("irq_masked", 0, {31'h0, irq});
    wb(1, ptm_pkg::IDX_PERIPHERAL_IRQ_FLAGS, 8'h00);
    wb(0, ptm_pkg::IDX_PERIPHERAL_IRQ_FLAGS, 0); chk("flag_cleared", 0, rd);
    $display("test postscale done");
    // stopped timer holds; control write keeps the count
    wb(1, ptm_pkg::IDX_PERIOD_TIMER_CONTROL, 8'h04);
    repeat (7) @(posedge mclk);
    wb(1, ptm_pkg::IDX_PERIOD_TIMER_CONTROL, 8'h00);
    // a non-zero count, so a control write that clears it shows up
    t0 = 1 + ($random(seed) & 127);
    wb(1, ptm_pkg::IDX_PERIOD_TIMER_COUNT, t0[7:0]);
    repeat (100) @(posedge mclk);
    wb(0, ptm_pkg::IDX_PERIOD_TIMER_COUNT, 0); chk("count_stopped", t0, rd);
    wb(1, ptm_pkg::IDX_PERIOD_TIMER_CONTROL, 8'h7b);
    wb(0, ptm_pkg::IDX_PERIOD_TIMER_COUNT, 0); chk("count_after_ctl", t0, rd);
    $display("test stop done");
    // count write restarts the 1:16 prescaler: first advance 61..64 cycles on
    wb(1, ptm_pkg::IDX_PERIOD_TIMER_CONTROL, 8'h06);
    repeat (($random(seed) & 31) + 3) @(posedge mclk);
    wb(1, ptm_pkg::IDX_PERIOD_TIMER_COUNT, 8'h00);
    k = 0;
    do begin
      @(negedge mclk);
      k++;
    end while (tb_count === 8'h00 && k < 200);
    // advance 61..64 cycles after the write edge, seen at the next falling edge
    chk("first_advance", 1, {31'h0, (k >= 62 && k <= 65)});
    $display("test scaler clear done");
    // mid-run reset with the timer running puts count, period, control and enables back
    repeat (20) @(posedge mclk);
    rst <= 1'b1;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    wb(0, ptm_pkg::IDX_PERIOD_TIMER_COUNT, 0); chk("count_rst", 0, rd);
    wb(0, ptm_pkg::IDX_PERIOD_LIMIT, 0); chk("period_rst", 32'hff, rd);
    wb(0, ptm_pkg::IDX_PERIOD_TIMER_CONTROL, 0); chk("control_rst", 0, rd);
    wb(0, ptm_pkg::IDX_PERIPHERAL_IRQ_ENABLES, 0); chk("enables_rst", 0, rd);
    $display("test mid-run reset done");
    tally_and_finish();
  end
endmodule

`default_nettype wire
